//--- irq_if.sv
`timescale 1ns/10ps
// event, mask and clear signals between the register bank and the irq unit
interface irq_if #(parameter int N = 3);
  logic [N-1:0] event_set;
  logic [N-1:0] clear;
  logic [N-1:0] enable;
  logic [N-1:0] status;
  logic irq;
  modport src (output event_set, output clear, output enable, input status, input irq);
  modport unit (input event_set, input clear, input enable, output status, output irq);
endinterface

//--- irq_unit.sv
`timescale 1ns/10ps
module irq_unit import lin_vec_pkg::*; #(
  parameter int N = NUM_EVENTS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  irq_if.unit bus
);
  logic [N-1:0] status_r;

  // sticky bits, a new event wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sticky
      logic status_nxt;
      assign status_nxt = bus.event_set[g] | (status_r[g] & ~bus.clear[g]);
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          status_r[g] <= 1'b0;
        end else begin
          status_r[g] <= status_nxt;
        end
      end
    end
  endgenerate

  // level output while any enabled bit is set
  assign bus.status = status_r;
  assign bus.irq = |(status_r & bus.enable);
endmodule

//--- lin_vec_pkg.sv
package lin_vec_pkg;
  // register byte offsets on the avalon slave
  localparam logic [4:0] ADDR_VECTOR = 5'h00;
  localparam logic [4:0] ADDR_FORMAT = 5'h04;
  localparam logic [4:0] ADDR_MODE = 5'h08;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0C;
  localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h10;
  localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h14;
  // field layout
  localparam int VEC_W = 5;
  localparam int LEN_LSB = 16;
  localparam int LEN_W = 3;
  localparam int CHAR_LSB = 0;
  localparam int CHAR_W = 3;
  localparam int MODE_LIN_BIT = 0;
  localparam int MODE_BUF_BIT = 1;
  // flags that a vector read never clears, and the flag count
  localparam int RX_FLAG_BIT = 9;
  localparam int TX_FLAG_BIT = 8;
  localparam int FLAG_COUNT = 31;
  // reset values and the fixed lin character width
  localparam logic [2:0] LEN_RESET = 3'h0;
  localparam logic [2:0] CHAR_RESET = 3'h0;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] LIN_CHAR_WIDTH = 4'h8;
  // event bits of the interrupt status register
  localparam int NUM_EVENTS = 3;
  localparam int EV_PENDING = 0;
  localparam int EV_FORMAT_WR = 1;
  localparam int EV_EMPTY_READ = 2;
  localparam logic [NUM_EVENTS-1:0] EV_RESET = 3'h0;
  // bus handshake states
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_type;
endpackage

//--- lin_vec_regs.sv
`timescale 1ns/10ps
module lin_vec_regs import lin_vec_pkg::*; #(
  parameter int NUM_FLAGS = FLAG_COUNT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [NUM_FLAGS-1:0] i_flags,
  output logic [NUM_FLAGS-1:0] o_flag_clr,
  output logic o_lin_mode,
  output logic o_buffered_mode,
  output logic [3:0] o_frame_count,
  output logic [3:0] o_char_width,
  output logic o_irq
);
  bus_state_type state_r;
  bus_state_type state_nxt;
  logic [31:0] readdata_r;
  logic [LEN_W-1:0] len_r;
  logic [CHAR_W-1:0] char_r;
  logic [1:0] mode_r;
  logic [NUM_EVENTS-1:0] enable_r;
  logic [NUM_FLAGS-1:0] clr_r;
  logic [NUM_FLAGS-1:0] clr_nxt;
  logic [NUM_FLAGS-1:0] served_r;
  logic [NUM_FLAGS-1:0] served_nxt;
  logic any_prev_r;
  logic [NUM_FLAGS-1:0] pend;
  logic [VEC_W-1:0] enc_code;
  logic enc_any;
  logic [31:0] rd_word;

  irq_if #(.N(NUM_EVENTS)) irq_bus ();

  // flags that a vector read must leave alone
  function automatic logic is_protected(input int idx);
    return (idx == RX_FLAG_BIT) || (idx == TX_FLAG_BIT);
  endfunction

  // address decode
  wire req = i_avs_read | i_avs_write;
  wire sel_vector = (i_avs_address == ADDR_VECTOR);
  wire sel_format = (i_avs_address == ADDR_FORMAT);
  wire sel_mode = (i_avs_address == ADDR_MODE);
  wire sel_status = (i_avs_address == ADDR_IRQ_STATUS);
  wire sel_clear = (i_avs_address == ADDR_IRQ_CLEAR);
  wire sel_enable = (i_avs_address == ADDR_IRQ_ENABLE);

  // one wait state: request latched, then accepted on the next edge
  wire accept = req & (state_r == BUS_ACK);
  wire latch_rd = i_avs_read & (state_r == BUS_IDLE);
  wire wr_acc = accept & i_avs_write;
  wire rd_vec = accept & i_avs_read & sel_vector;
  assign state_nxt = (req && state_r == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
  assign o_avs_waitrequest = req & (state_r != BUS_ACK);
  assign o_avs_readdata = readdata_r;

  // code handed to software is the one latched for this access
  wire [VEC_W-1:0] ret_code = readdata_r[VEC_W-1:0];

  // flags being cleared or already served are hidden from the encoder
  assign pend = i_flags & ~served_r & ~clr_r;

  offset_encoder #(.NUM_FLAGS(NUM_FLAGS)) u_enc (
    .i_req(pend),
    .o_code(enc_code),
    .o_any(enc_any)
  );

  // read mux, reserved and unmapped bits return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_vector) begin
      rd_word[VEC_W-1:0] = enc_code;
    end else if (sel_format) begin
      rd_word[LEN_LSB+:LEN_W] = len_r;
      rd_word[CHAR_LSB+:CHAR_W] = char_r;
    end else if (sel_mode) begin
      rd_word[1:0] = mode_r;
    end else if (sel_status) begin
      rd_word[NUM_EVENTS-1:0] = irq_bus.status;
    end else if (sel_enable) begin
      rd_word[NUM_EVENTS-1:0] = enable_r;
    end
  end

  // clear pulse and served marks per flag
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      wire hit = rd_vec & (ret_code == VEC_W'(g + 1));
      if (is_protected(g)) begin : g_prot
        assign clr_nxt[g] = 1'b0;
        assign served_nxt[g] = (served_r[g] | hit) & i_flags[g];
      end else begin : g_norm
        assign clr_nxt[g] = hit;
        assign served_nxt[g] = 1'b0;
      end
    end
  endgenerate
  assign o_flag_clr = clr_r;

  // bus state and read data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= BUS_IDLE;
      readdata_r <= 32'h0000_0000;
    end else begin
      state_r <= state_nxt;
      if (latch_rd) begin
        readdata_r <= rd_word;
      end
    end
  end

  // vector side effects
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_r <= '0;
      served_r <= '0;
      any_prev_r <= 1'b0;
    end else begin
      clr_r <= clr_nxt;
      served_r <= served_nxt;
      any_prev_r <= enc_any;
    end
  end

  // format register, byte lane 2 holds length, lane 0 holds width
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      len_r <= LEN_RESET;
      char_r <= CHAR_RESET;
    end else if (wr_acc && sel_format) begin
      if (i_avs_byteenable[2]) begin
        len_r <= i_avs_writedata[LEN_LSB+:LEN_W];
      end
      if (i_avs_byteenable[0]) begin
        char_r <= i_avs_writedata[CHAR_LSB+:CHAR_W];
      end
    end
  end

  // mode and interrupt enable registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_r <= MODE_RESET;
      enable_r <= EV_RESET;
    end else if (wr_acc && i_avs_byteenable[0]) begin
      if (sel_mode) begin
        mode_r <= i_avs_writedata[1:0];
      end
      if (sel_enable) begin
        enable_r <= i_avs_writedata[NUM_EVENTS-1:0];
      end
    end
  end

  // decoded modes and counts for the serial engines
  assign o_lin_mode = mode_r[MODE_LIN_BIT];
  assign o_buffered_mode = mode_r[MODE_BUF_BIT] & ~mode_r[MODE_LIN_BIT];
  assign o_frame_count = {1'b0, len_r} + 4'h1;
  assign o_char_width = o_lin_mode ? LIN_CHAR_WIDTH : ({1'b0, char_r} + 4'h1);

  // events into the interrupt unit
  assign irq_bus.event_set[EV_PENDING] = enc_any & ~any_prev_r;
  assign irq_bus.event_set[EV_FORMAT_WR] = wr_acc & sel_format;
  assign irq_bus.event_set[EV_EMPTY_READ] = rd_vec & (ret_code == '0);
  assign irq_bus.clear = (wr_acc && sel_clear && i_avs_byteenable[0]) ?
                         i_avs_writedata[NUM_EVENTS-1:0] : '0;
  assign irq_bus.enable = enable_r;
  assign o_irq = irq_bus.irq;

  irq_unit #(.N(NUM_EVENTS)) u_irq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(irq_bus)
  );

  // handshake takes exactly one wait state
  a_bus_one_wait: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (req && state_r == BUS_IDLE) |-> o_avs_waitrequest ##1 (!o_avs_waitrequest || !req))
    else $error("request not answered after one wait state");

  // latched vector value is the encoder output of the latch cycle
  a_vec_value: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (latch_rd && sel_vector) |=> (o_avs_readdata[VEC_W-1:0] == $past(enc_code)))
    else $error("vector read data differs from pending offset");

  // reserved bits of vector and format reads stay zero
  a_upper_zero: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (accept && i_avs_read && (sel_vector || sel_format)) |->
    (o_avs_readdata[31:19] == 13'h0000 && o_avs_readdata[15:5] == 11'h000))
    else $error("reserved bits read nonzero");

  // returned offset one has flag 0 alone cleared on the next cycle
  a_read_clears: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (rd_vec && ret_code == 5'h01) |=> (o_flag_clr[0] && $onehot(o_flag_clr)))
    else $error("flag of returned offset not cleared");

  // receive and transmit flags are never pulsed
  a_protect_flags: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !(o_flag_clr[RX_FLAG_BIT] || o_flag_clr[TX_FLAG_BIT]))
    else $error("protected flag cleared by vector read");

  // at most one flag cleared, only right after a vector read
  a_single_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_flag_clr != '0) |-> ($onehot(o_flag_clr) && $past(rd_vec)))
    else $error("flag clear without a single vector read");

  // the code just returned is not offered again
  a_next_offset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (rd_vec && ret_code != 5'h00) |=> (enc_code != $past(ret_code)))
    else $error("same offset reported twice");

  // written length appears as count plus one
  a_frame_count: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (wr_acc && sel_format && i_avs_byteenable[2]) |=>
    (o_frame_count == ({1'b0, $past(i_avs_writedata[18:16])} + 4'h1)))
    else $error("frame count does not follow length code");

  // width field is ignored in lin mode
  a_char_width: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    o_lin_mode |-> (o_char_width == 4'h8))
    else $error("character width not fixed in lin mode");

  // vector reads show nothing above the five-bit offset
  a_vector_zero_hi: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (latch_rd && sel_vector) |=> (o_avs_readdata[31:5] == 27'h0000000))
    else $error("vector read shows bits above the offset");

  // format reads show only the length and width fields
  a_format_zero_hi: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (latch_rd && sel_format) |=>
    (o_avs_readdata[31:19] == 13'h0000 && o_avs_readdata[15:3] == 13'h0000))
    else $error("format read shows reserved bits");

  // pending flag 0, the lowest, is the one offered
  a_lowest_first: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    pend[0] |-> (enc_code == 5'h01))
    else $error("lowest pending flag not offered first");

  // a served receive flag is skipped while it stays high
  a_served_skip: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (served_r[RX_FLAG_BIT] && i_flags[RX_FLAG_BIT]) |->
    (enc_code != VEC_W'(RX_FLAG_BIT + 1)))
    else $error("served receive flag offered again");

  // any unprotected returned offset has its own flag cleared
  a_clear_offset: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (rd_vec && ret_code != 5'h00 && !is_protected(int'(ret_code) - 1)) |=>
    o_flag_clr[$past(ret_code) - 5'h01])
    else $error("returned offset left its flag set");

  // an empty read clears nothing
  a_empty_no_clear: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (rd_vec && ret_code == 5'h00) |=> (o_flag_clr == '0))
    else $error("empty vector read cleared a flag");

  // a clear pulse lasts one cycle
  a_clear_one_cycle: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_flag_clr != '0) |=> (o_flag_clr == '0))
    else $error("clear pulse longer than one cycle");

  // code six gives seven bytes
  a_len_seven: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (len_r == 3'h6) |-> (o_frame_count == 4'h7))
    else $error("length code six not seven bytes");

  // code seven gives eight bytes
  a_len_eight: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (len_r == 3'h7) |-> (o_frame_count == 4'h8))
    else $error("length code seven not eight bytes");

  // serial modes: width code zero is a one-bit character
  a_char_one: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    (!o_lin_mode && char_r == 3'h0) |-> (o_char_width == 4'h1))
    else $error("width code zero not one bit");
endmodule

//--- lin_vec_regs_tb.sv
`timescale 1ns/10ps
module lin_vec_regs_tb import lin_vec_pkg::*; ();
  logic i_clk, i_rst_n, rd_en, wr_en;
  logic [4:0] addr;
  logic [31:0] wdata, seed, q, r;
  logic [3:0] be;
  logic [30:0] flags, flag_set, flag_drop, served;
  logic [4:0] code;
  wire logic [31:0] rdata;
  wire logic wait_req, lin_mode, buf_mode, irq;
  wire logic [30:0] flag_clr;
  wire logic [3:0] frame_count, char_width;
  int bad_count, checks, n;

  lin_vec_regs lin_vec_regs_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_flags(flags),
    .o_flag_clr(flag_clr), .o_lin_mode(lin_mode), .o_buffered_mode(buf_mode),
    .o_frame_count(frame_count), .o_char_width(char_width), .o_irq(irq));

  // clock, 40 ns period
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // flag source drops a flag at the edge that ends its clear pulse
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flag_clr & ~flag_drop) | flag_set;
    end
  end

  // watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    finish_test();
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // lowest pending index wins, code is index plus one
  function automatic logic [4:0] exp_code(input logic [30:0] pend);
    for (int i = 0; i < 31; i++) begin
      if (pend[i]) return 5'(i + 1);
    end
    return 5'h00;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // avalon cycle: hold until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] rq);
    logic w;
    w = 1'b1;
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    be <= b;
    rd_en <= !wr;
    wr_en <= wr;
    while (w) begin
      @(posedge i_clk);
      w = wait_req;
      rq = rdata;
    end
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  task automatic setf(input logic [30:0] s, input logic [30:0] d);
    @(posedge i_clk);
    flag_set <= s;
    flag_drop <= d;
    @(posedge i_clk);
    flag_set <= 31'h0;
    flag_drop <= 31'h0;
    @(posedge i_clk);
  endtask

  // vector read with offset and clear pulse checked together
  task automatic rdvec(output logic [4:0] c);
    logic [4:0] e;
    logic [30:0] clr;
    // settle first: a clear pulse still standing means its flag drops at the next edge
    @(negedge i_clk);
    e = exp_code(flags & ~flag_clr & ~served);
    clr = (e == 5'h00 || e == 5'h09 || e == 5'h0A) ? 31'h0 : 31'h1 << (e - 1);
    bus(1'b0, ADDR_VECTOR, 32'h0, 4'hF, q);
    chk(q, {27'h0, e});
    @(negedge i_clk);
    chk({1'b0, flag_clr}, {1'b0, clr});
    if (e == 5'h09 || e == 5'h0A) served[e - 1] = 1'b1;
    c = e;
  endtask

  task automatic finish_test();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {rd_en, wr_en, addr, wdata, be} = '0;
    {flag_set, flag_drop, served} = '0;
    seed = 32'h000063D1;
    i_rst_n = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk({24'h0, frame_count, char_width}, 32'h00000011);
    // every length and char code, random reserved bits
    for (int c = 0; c < 8; c++) begin
      r = (xs() & ~32'h00070007) | (32'(c) << 16) | 32'(7 - c);
      bus(1'b1, ADDR_FORMAT, r, 4'hF, q);
      bus(1'b0, ADDR_FORMAT, 32'h0, 4'hF, q);
      chk(q, (32'(c) << 16) | 32'(7 - c));
      @(negedge i_clk);
      chk({28'h0, frame_count}, 32'(c + 1));
      chk({28'h0, char_width}, 32'(8 - c));
    end
    // only lane 0 enabled: length stays
    bus(1'b1, ADDR_FORMAT, 32'h00050005, 4'h1, q);
    bus(1'b0, ADDR_FORMAT, 32'h0, 4'hF, q);
    chk(q, 32'h00070005);
    bus(1'b1, ADDR_MODE, 32'h1, 4'hF, q);
    @(negedge i_clk);
    chk({lin_mode, buf_mode, frame_count, char_width}, {2'b10, 4'h8, LIN_CHAR_WIDTH});
    // identifier matched: software rewrites only the length lane
    bus(1'b1, ADDR_FORMAT, 32'h00020005, 4'h4, q);
    @(negedge i_clk);
    chk({28'h0, frame_count}, 32'h3);
    bus(1'b1, ADDR_MODE, 32'h2, 4'hF, q);
    @(negedge i_clk);
    chk({lin_mode, buf_mode, frame_count, char_width}, {2'b01, 8'h36});
    bus(1'b0, 5'h1C, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    // random pending sets, drained by back to back reads
    for (int k = 0; k < 4; k++) begin
      r = xs();
      setf(r[30:0] | 31'h00000300, 31'h0);
      bus(1'b1, ADDR_VECTOR, xs(), 4'hF, q);
      n = 0;
      code = 5'h1F;
      while (code != 5'h00 && n < 40) begin
        rdvec(code);
        n++;
      end
      chk({27'h0, code}, 32'h0);
      chk({30'h0, flags[9:8]}, 32'h3);
      setf(31'h0, 31'h00000300);
      served = served & flags;
      rdvec(code);
    end
    setf(31'h40000200, 31'h0);
    rdvec(code);
    rdvec(code);
    setf(31'h0, 31'h00000200);
    served = served & flags;
    // pending appears, then an empty read: status bits 0 and 2 only
    bus(1'b1, ADDR_IRQ_CLEAR, 32'h7, 4'hF, q);
    setf(31'h00000001, 31'h0);
    rdvec(code);
    rdvec(code);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 4'hF, q);
    chk(q, 32'h5);
    // interrupt raise, clear, mask
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h2, 4'hF, q);
    bus(1'b1, ADDR_IRQ_CLEAR, 32'h7, 4'hF, q);
    bus(1'b1, ADDR_FORMAT, 32'h00030003, 4'hF, q);
    @(negedge i_clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 4'hF, q);
    chk(q & 32'h2, 32'h2);
    bus(1'b1, ADDR_IRQ_CLEAR, 32'h2, 4'hF, q);
    @(negedge i_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_IRQ_ENABLE, 32'h0, 4'hF, q);
    bus(1'b1, ADDR_FORMAT, 32'h00010001, 4'hF, q);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0, 4'hF, q);
    chk({30'h0, q[1], irq}, 32'h2);
    // reset in mid-run puts every register back to its reset value
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk({21'h0, lin_mode, buf_mode, irq, frame_count, char_width}, 32'h00000011);
    bus(1'b0, ADDR_FORMAT, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    finish_test();
  end
endmodule

//--- offset_encoder.sv
`timescale 1ns/10ps
module offset_encoder import lin_vec_pkg::*; #(
  parameter int NUM_FLAGS = FLAG_COUNT
) (
  input wire logic [NUM_FLAGS-1:0] i_req,
  output logic [VEC_W-1:0] o_code,
  output logic o_any
);
  // lowest flag index wins; code is index plus one, zero means none
  always_comb begin
    o_code = '0;
    for (int i = NUM_FLAGS - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_code = VEC_W'(i + 1);
      end
    end
  end

  assign o_any = |i_req;
endmodule
